/* sbp_map.svh */
/*
  constants for the system bus parity and arbitration pin block:
  widths, lane counts, reset values.
  assumes it is included by its bare name from the package and the modules.
*/
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH

// data bus width and the byte lanes that carry a parity bit each
`define SBP_DATA_W     64
`define SBP_LANES      8
`define SBP_LANE_W     8

// external interrupt lines and dma request inputs
`define SBP_IRQ_N      8
`define SBP_DMA_N      2

// arbitration: three contenders, core plus two external masters
`define SBP_MASTERS    3
`define SBP_IDX_W      2
`define SBP_GRANT_RST  3'h0
`define SBP_LAST_RST   2'h0

// output reset values
`define SBP_DATA_RST   64'h0000_0000_0000_0000
`define SBP_LANE_RST   8'h00
`define SBP_IRQ_RST    8'h00
`define SBP_DMA_RST    2'h0

`endif

/* sbp_pkg.sv */
/*
  types shared by the parity and arbitration pin block.
  assumes sbp_map.svh is on the include path.
*/
`include "sbp_map.svh"

package sbp_pkg;

  // one bit per bus contender, at most one set at a time
  typedef struct packed {
    logic m3;    // external master 3, second of the two external masters
    logic m2;    // external master 2, first of the two external masters
    logic core;  // internal masters of the device
  } sbp_grant_t;

  // arbiter tenure states
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_ADDR,
    ARB_DATA
  } sbp_arb_state_t;

  // one parity answer: generated lanes and lanes found in error
  typedef struct packed {
    logic [`SBP_LANES-1:0] gen;
    logic [`SBP_LANES-1:0] bad;
  } sbp_parity_t;

endpackage : sbp_pkg

/* sbp_parity.sv */
/*
  byte-lane odd parity generator and checker for the 64-bit data bus.
  purely combinational; assumes the caller registers what it drives out.
*/
`timescale 1ns/1ps
`include "sbp_map.svh"

module sbp_parity (
  input  wire logic [`SBP_DATA_W-1:0] data,
  input  wire logic [`SBP_LANES-1:0]  lanes_in,
  output sbp_pkg::sbp_parity_t        result
);

  // lane bit that makes the byte plus itself hold an odd count of ones
  function automatic logic odd_bit(input logic [`SBP_LANE_W-1:0] b);
    odd_bit = ~(^b);
  endfunction : odd_bit

  ////////////////////////////////////////////////////////////////////////
  // lane i covers data bits 8i..8i+7
  always_comb begin
    result = '0;
    for (int i = 0; i < `SBP_LANES; i++) begin
      result.gen[i] = odd_bit(data[i*`SBP_LANE_W +: `SBP_LANE_W]);
      result.bad[i] = result.gen[i] ^ lanes_in[i];
    end
  end

endmodule : sbp_parity

/* sbp_top.sv */
/*
  system bus pin logic: parity on the 64-bit data bus, external bus
  arbitration with split address and data grants, dma request and
  external interrupt pass-through toward the internal controllers.
  assumes all inputs are synchronous to sys_clk and the pad ring resolves
  the data and parity pins from the output enables.
*/
`timescale 1ns/1ps
`include "sbp_map.svh"

module sbp_top (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // data bus pins, resolved outside
  input  wire logic [`SBP_DATA_W-1:0] data_bus_in,
  output logic      [`SBP_DATA_W-1:0] data_bus_out,
  output logic                        data_bus_oe,
  input  wire logic [`SBP_LANES-1:0]  parity_lane_in,
  output logic      [`SBP_LANES-1:0]  parity_lane_out,
  output logic      [`SBP_LANES-1:0]  parity_lane_oe,
  // internal agent placing a beat
  input  wire logic                   core_drive,
  input  wire logic [`SBP_DATA_W-1:0] core_wdata,
  // external beat strobe and its check result
  input  wire logic                   ext_beat_valid,
  output logic                        parity_err,
  output logic      [`SBP_LANES-1:0]  parity_err_lanes,
  // arbitration
  input  wire logic                   core_request,
  input  wire logic                   ext_master2_request,
  input  wire logic                   ext_master3_request,
  input  wire logic                   addr_tenure_done,
  input  wire logic                   data_tenure_done,
  output logic                        core_addr_grant,
  output logic                        core_data_grant,
  output logic                        ext_master2_addr_grant,
  output logic                        ext_master3_addr_grant,
  output logic                        ext_master2_data_grant,
  output logic                        ext_master3_data_grant,
  // dma and interrupt lines
  input  wire logic [`SBP_DMA_N-1:0]  dma_chan_request,
  output logic      [`SBP_DMA_N-1:0]  dma_req_to_engine,
  input  wire logic [`SBP_IRQ_N-1:0]  ext_int_line_n,
  output logic      [`SBP_IRQ_N-1:0]  irq_to_intc
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [`SBP_DATA_W-1:0] data_r,     data_nxt;     // beat on the pins
  logic                   oe_r,       oe_nxt;       // device owns data bus
  logic [`SBP_LANES-1:0]  lane_r,     lane_nxt;     // parity beside beat
  logic                   perr_r,     perr_nxt;     // one-cycle error flag
  logic [`SBP_LANES-1:0]  plane_r,    plane_nxt;    // lanes in error
  sbp_pkg::sbp_parity_t   gen_res;                  // parity of core data
  sbp_pkg::sbp_parity_t   chk_res;                  // check of pin data

  sbp_pkg::sbp_arb_state_t st_r,  st_nxt;           // tenure state
  sbp_pkg::sbp_grant_t     ag_r,  ag_nxt;           // address grants
  sbp_pkg::sbp_grant_t     dg_r,  dg_nxt;           // data grants
  sbp_pkg::sbp_grant_t     own_r, own_nxt;          // current tenure owner
  logic [`SBP_IDX_W-1:0]   last_r, last_nxt;        // last served index
  logic [`SBP_MASTERS-1:0] req_vec;                 // requests by index

  logic [`SBP_DMA_N-1:0]   dma_r, dma_nxt;          // dma requests
  logic [`SBP_IRQ_N-1:0]   irq_r, irq_nxt;          // interrupts, high true

  // round robin: first requester after the last one served wins
  function automatic sbp_pkg::sbp_grant_t rr_pick(
    input logic [`SBP_MASTERS-1:0] req,
    input logic [`SBP_IDX_W-1:0]   last
  );
    logic [`SBP_MASTERS-1:0] g;
    logic [2:0]              idx;
    g = '0;
    // walk backwards so the nearest candidate overwrites the rest
    for (int k = `SBP_MASTERS; k >= 1; k--) begin
      idx = 3'({1'b0, last}) + 3'(k);
      if (idx >= 3'(`SBP_MASTERS)) begin
        idx = idx - 3'(`SBP_MASTERS);
      end
      if (req[idx[1:0]]) begin
        g = '0;
        g[idx[1:0]] = 1'b1;
      end
    end
    rr_pick = sbp_pkg::sbp_grant_t'(g);
  endfunction : rr_pick

  ////////////////////////////////////////////////////////////////////////
  // parity generation on the outgoing beat and check on the incoming one
  sbp_parity u_gen (
    .data     (core_wdata),
    .lanes_in (`SBP_LANE_RST),
    .result   (gen_res)
  );

  sbp_parity u_chk (
    .data     (data_bus_in),
    .lanes_in (parity_lane_in),
    .result   (chk_res)
  );

  // next beat: parity taken from the same word so both leave together
  always_comb begin
    data_nxt  = data_r;
    oe_nxt    = core_drive;
    lane_nxt  = lane_r;
    perr_nxt  = 1'b0;
    plane_nxt = plane_r;
    if (core_drive) begin
      data_nxt = core_wdata;
      lane_nxt = gen_res.gen;
    end
    // only check beats the far side drove; our own would self-compare
    if (!oe_r && ext_beat_valid) begin
      perr_nxt  = |chk_res.bad;
      plane_nxt = chk_res.bad;
    end
  end

  // data path registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_r  <= `SBP_DATA_RST;
      oe_r    <= 1'b0;
      lane_r  <= `SBP_LANE_RST;
      perr_r  <= 1'b0;
      plane_r <= `SBP_LANE_RST;
    end else begin
      data_r  <= data_nxt;
      oe_r    <= oe_nxt;
      lane_r  <= lane_nxt;
      perr_r  <= perr_nxt;
      plane_r <= plane_nxt;
    end
  end

  assign data_bus_out     = data_r;
  assign data_bus_oe      = oe_r;
  assign parity_lane_out  = lane_r;
  assign parity_lane_oe   = {`SBP_LANES{oe_r}};
  assign parity_err       = perr_r;
  assign parity_err_lanes = plane_r;

  ////////////////////////////////////////////////////////////////////////
  // arbitration: address tenure, then data tenure, then release
  assign req_vec = {ext_master3_request, ext_master2_request, core_request};

  always_comb begin
    st_nxt   = st_r;
    ag_nxt   = ag_r;
    dg_nxt   = dg_r;
    own_nxt  = own_r;
    last_nxt = last_r;
    case (st_r)
      sbp_pkg::ARB_IDLE: begin
        // a grant goes out only for a live request
        if (|req_vec) begin
          own_nxt = rr_pick(req_vec, last_r);
          ag_nxt  = own_nxt;
          st_nxt  = sbp_pkg::ARB_ADDR;
        end
      end
      sbp_pkg::ARB_ADDR: begin
        // grant held until the address tenure ends, even if request drops
        if (addr_tenure_done) begin
          ag_nxt = '0;
          dg_nxt = own_r;
          st_nxt = sbp_pkg::ARB_DATA;
        end
      end
      sbp_pkg::ARB_DATA: begin
        if (data_tenure_done) begin
          dg_nxt   = '0;
          st_nxt   = sbp_pkg::ARB_IDLE;
          last_nxt = own_r.m3 ? 2'h2 : (own_r.m2 ? 2'h1 : 2'h0);
          own_nxt  = '0;
        end
      end
      default: begin
        st_nxt  = sbp_pkg::ARB_IDLE;
        ag_nxt  = '0;
        dg_nxt  = '0;
        own_nxt = '0;
      end
    endcase
  end

  // arbiter registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r   <= sbp_pkg::ARB_IDLE;
      ag_r   <= `SBP_GRANT_RST;
      dg_r   <= `SBP_GRANT_RST;
      own_r  <= `SBP_GRANT_RST;
      last_r <= `SBP_LAST_RST;
    end else begin
      st_r   <= st_nxt;
      ag_r   <= ag_nxt;
      dg_r   <= dg_nxt;
      own_r  <= own_nxt;
      last_r <= last_nxt;
    end
  end

  assign core_addr_grant        = ag_r.core;
  assign core_data_grant        = dg_r.core;
  assign ext_master2_addr_grant = ag_r.m2;
  assign ext_master3_addr_grant = ag_r.m3;
  assign ext_master2_data_grant = dg_r.m2;
  assign ext_master3_data_grant = dg_r.m3;

  ////////////////////////////////////////////////////////////////////////
  // dma requests and interrupt lines, one register stage each
  always_comb begin
    dma_nxt = dma_chan_request;
    irq_nxt = ~ext_int_line_n;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dma_r <= `SBP_DMA_RST;
      irq_r <= `SBP_IRQ_RST;
    end else begin
      dma_r <= dma_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign dma_req_to_engine = dma_r;
  assign irq_to_intc       = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // address tenure closes for master 2: its data grant follows
  sequence s_addr_close_m2;
    ext_master2_addr_grant && addr_tenure_done;
  endsequence
  sequence s_data_hold_m2;
    ext_master2_data_grant && !ext_master2_addr_grant;
  endsequence

  AST_PAR_OE_TRACK: assert property (core_drive |=> data_bus_oe && (&parity_lane_oe))
    else $error("parity lanes not driven with data");
  AST_PAR_OE_EQUAL: assert property (parity_lane_oe == {`SBP_LANES{data_bus_oe}})
    else $error("parity enable differs from data enable");
  AST_LANE0_ODD: assert property (data_bus_oe |-> ^{parity_lane_out[0], data_bus_out[7:0]})
    else $error("lane 0 parity not odd");
  AST_LANE1_ODD: assert property (data_bus_oe |->
      ^{parity_lane_out[1], data_bus_out[15:8]})
    else $error("lane 1 parity not odd");
  AST_LANE2_ODD: assert property (data_bus_oe |->
      ^{parity_lane_out[2], data_bus_out[23:16]})
    else $error("lane 2 parity not odd");
  AST_LANE3_ODD: assert property (data_bus_oe |->
      ^{parity_lane_out[3], data_bus_out[31:24]})
    else $error("lane 3 parity not odd");
  AST_LANE4_ODD: assert property (data_bus_oe |->
      ^{parity_lane_out[4], data_bus_out[39:32]})
    else $error("lane 4 parity not odd");
  AST_LANE5_ODD: assert property (data_bus_oe |->
      ^{parity_lane_out[5], data_bus_out[47:40]})
    else $error("lane 5 parity not odd");
  AST_LANE6_ODD: assert property (data_bus_oe |->
      ^{parity_lane_out[6], data_bus_out[55:48]})
    else $error("lane 6 parity not odd");
  AST_LANE7_ODD: assert property (data_bus_oe |->
      ^{parity_lane_out[7], data_bus_out[63:56]})
    else $error("lane 7 parity not odd");
  AST_ADDR_GRANT_CAUSE: assert property ($rose(ext_master3_addr_grant) |->
      $past(ext_master3_request))
    else $error("address grant without request");
  AST_DATA_AFTER_ADDR: assert property (s_addr_close_m2 |=> s_data_hold_m2)
    else $error("data grant missing after address tenure");
  AST_ONE_ADDR_OWNER: assert property ($onehot0(ag_r) && $onehot0(dg_r))
    else $error("more than one grant owner");
  AST_DMA_FOLLOW: assert property (dma_chan_request == 2'h3 |=> dma_req_to_engine == 2'h3)
    else $error("dma request not forwarded");
  AST_IRQ_ROUTE: assert property (irq_to_intc == ~$past(ext_int_line_n))
    else $error("interrupt line not routed");

endmodule : sbp_top

/* sbp_far.sv */
/*
  far side model: two external masters asking for the bus and an
  external agent placing data beats with their parity lanes.
  assumes the bench resolves the shared data and parity pins from the
  device's output enables.
*/
`timescale 1ns/1ps
module sbp_far (
  input  wire logic [1:0]  want,
  input  wire logic        beat_go,
  input  wire logic [63:0] beat_data,
  input  wire logic [7:0]  beat_flip,
  output logic             ext_master2_request,
  output logic             ext_master3_request,
  output logic [63:0]      far_data,
  output logic [7:0]       far_par
);
  logic [7:0] good;  // odd parity of each byte lane

  ////////////////////////////////////////////////////////////////////////////
  // request level held for as long as the master wants the bus
  assign ext_master2_request = want[0];
  assign ext_master3_request = want[1];

  // lane i covers byte i; flip marks lanes sent wrong on purpose
  always_comb begin
    for (int i = 0; i < 8; i++) good[i] = ~^beat_data[8*i+:8];
  end

  // released pins show the inverse, so a stale beat never looks valid
  assign far_data = beat_go ? beat_data : ~beat_data;
  assign far_par  = beat_go ? (good ^ beat_flip) : ~good;
endmodule : sbp_far

/* tb.sv */
/*
  self-checking bench for the system bus pin block: random beats both
  ways with parity, round robin tenures, interrupt and dma lines.
  assumes sbp_map.svh, sbp_pkg, sbp_top and sbp_far are compiled first.
*/
`timescale 1ns/1ps
`include "sbp_map.svh"
module tb;
  logic        sys_clk, rst_n, data_bus_oe, core_drive, ext_beat_valid, parity_err;
  logic        core_request, addr_tenure_done, data_tenure_done, beat_go;
  logic        core_addr_grant, core_data_grant, m2a, m3a, m2d, m3d, m2r, m3r;
  logic [63:0] data_bus_in, data_bus_out, core_wdata, beat_data, far_data, m_out;
  logic [7:0]  parity_lane_in, parity_lane_out, parity_lane_oe, parity_err_lanes;
  logic [7:0]  ext_int_line_n, irq_to_intc, beat_flip, far_par, m_irq, m_par, m_lanes;
  logic [1:0]  dma_chan_request, dma_req_to_engine, want, m_dma;
  logic        m_oe, m_err;  // model of the data path
  int          miscompares, compares, last;

  ////////////////////////////////////////////////////////////////////////////
  sbp_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .parity_lane_in(parity_lane_in), .parity_lane_out(parity_lane_out),
    .parity_lane_oe(parity_lane_oe), .core_drive(core_drive), .core_wdata(core_wdata),
    .ext_beat_valid(ext_beat_valid), .parity_err(parity_err),
    .parity_err_lanes(parity_err_lanes), .core_request(core_request),
    .ext_master2_request(m2r), .ext_master3_request(m3r),
    .addr_tenure_done(addr_tenure_done), .data_tenure_done(data_tenure_done),
    .core_addr_grant(core_addr_grant), .core_data_grant(core_data_grant),
    .ext_master2_addr_grant(m2a), .ext_master3_addr_grant(m3a),
    .ext_master2_data_grant(m2d), .ext_master3_data_grant(m3d),
    .dma_chan_request(dma_chan_request), .dma_req_to_engine(dma_req_to_engine),
    .ext_int_line_n(ext_int_line_n), .irq_to_intc(irq_to_intc));
  sbp_far FAR (.want(want), .beat_go(beat_go), .beat_data(beat_data),
    .beat_flip(beat_flip), .ext_master2_request(m2r), .ext_master3_request(m3r),
    .far_data(far_data), .far_par(far_par));

  // pad ring: the device wins wherever its enable is up
  assign data_bus_in    = data_bus_oe ? data_bus_out : far_data;
  assign parity_lane_in = (parity_lane_oe & parity_lane_out) | (~parity_lane_oe & far_par);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // odd parity per byte, counted rather than reduced
  function automatic logic [7:0] odd8(input logic [63:0] w);
    for (int i = 0; i < 8; i++) odd8[i] = ($countones(w[8*i+:8]) % 2) == 0;
  endfunction : odd8

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up;
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // one cycle: check the pass-through lines, then give them fresh values
  task automatic step;
    @(negedge sys_clk);
    chk("irq_to_intc", 8'(~m_irq), irq_to_intc);
    chk("dma_req_to_engine", m_dma, dma_req_to_engine);
    m_irq = 8'($urandom);
    m_dma = 2'($urandom);
    ext_int_line_n   = m_irq;
    dma_chan_request = m_dma;
  endtask : step

  // one whole tenure; requests held through the release and never dropped here
  task automatic tenure(input logic [2:0] rq);
    int w;
    logic [2:0] g;
    w = -1;
    for (int k = 1; k <= 3; k++) if (w < 0 && rq[(last + k) % 3]) w = (last + k) % 3;
    g = 3'(1 << w);
    last = w;
    core_request = rq[0];
    want = rq[2:1];
    step;
    chk("addr_grant", g, {m3a, m2a, core_addr_grant});
    chk("data_grant", 3'h0, {m3d, m2d, core_data_grant});
    addr_tenure_done = 1'b1;
    step;
    addr_tenure_done = 1'b0;
    chk("addr_grant", 3'h0, {m3a, m2a, core_addr_grant});
    chk("data_grant", g, {m3d, m2d, core_data_grant});
    data_tenure_done = 1'b1;
    step;
    data_tenure_done = 1'b0;
    chk("release", 6'h00, {m3a, m2a, core_addr_grant, m3d, m2d, core_data_grant});
  endtask : tenure

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {core_drive, ext_beat_valid, core_request, addr_tenure_done} = 4'h0;
    {data_tenure_done, beat_go, want, dma_chan_request, m_dma} = 8'h00;
    {core_wdata, beat_data, m_out} = '0;
    {beat_flip, m_par, m_lanes, m_oe, m_err, last} = '0;
    ext_int_line_n = 8'hFF;
    m_irq = 8'hFF;
    rst_n = 1'b0;
    void'($urandom(32'h97BA));
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    // one quiet cycle after release, then every output but data_bus_out must still be at rest
    step;
    chk("reset_state", 64'h0, {data_bus_oe, parity_lane_oe, parity_err, parity_err_lanes,
      parity_lane_out, m3a, m2a, core_addr_grant, m3d, m2d, core_data_grant});
    // random beats both ways; far beats while the device drives are ignored
    for (int n = 0; n < 80; n++) begin
      core_drive = 1'($urandom);
      ext_beat_valid = 1'($urandom);
      beat_go = ext_beat_valid;
      core_wdata = {$urandom, $urandom};
      beat_data = {$urandom, $urandom};
      beat_flip = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
      m_err = ext_beat_valid && !m_oe && (beat_flip != 8'h00);
      if (ext_beat_valid && !m_oe) m_lanes = beat_flip;
      m_oe = core_drive;
      if (core_drive) m_out = core_wdata;
      if (core_drive) m_par = odd8(m_out);
      step;
      chk("data_bus_oe", m_oe, data_bus_oe);
      chk("parity_lane_oe", {8{m_oe}}, parity_lane_oe);
      chk("data_bus_out", m_out, data_bus_out);
      chk("parity_lane_out", m_par, parity_lane_out);
      chk("parity_err", m_err, parity_err);
      chk("parity_err_lanes", m_lanes, parity_err_lanes);
    end
    core_drive = 1'b0;
    ext_beat_valid = 1'b0;
    beat_go = 1'b0;
    for (int t = 0; t < 16; t++) tenure(3'(1 + $urandom % 7));
    wrap_up;
  end

  // cut a hang short
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    wrap_up;
  end
endmodule : tb
